// >>> src/umc_modem_ctrl.sv
// Modem line control register and its pin, loopback and mode logic
module umc_modem_ctrl
    import umc_pkg::*;
#(
    parameter int PRE_DIV = PRESCALE_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Modem pins, active low
    input wire umc_lines_t modem_in_n,
    output logic rts_n,
    output logic dtr_n,
    output logic general_output_pin,
    // Interrupt pins
    input wire logic irq_a_req,
    input wire logic irq_b_req,
    output umc_tri_t channel_a_irq_out,
    output umc_tri_t channel_b_irq_out,
    // Serial path
    input wire logic tx_from_core,
    output logic txd_pin,
    input wire logic rxd_pin,
    output logic rx_to_core,
    // Flow control hardware
    input wire logic hw_rts_assert,
    // Mode outputs and baud tick
    output logic flow_threshold_access,
    output logic xon_any_en,
    output logic fifo_rdy_en,
    output logic loopback_en,
    output logic auto_rts_en,
    output logic baud_tick
);

    localparam int SYNC_W = LINES_W + 1;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0] modem_line_control_q;
    logic [DATA_W-1:0] modem_line_control_d;
    logic [DATA_W-1:0] enhanced_feature_reg_q;
    logic [DATA_W-1:0] enhanced_feature_reg_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_1_q;
    logic [SYNC_W-1:0] sync_2_q;
    umc_lines_t lines_n;
    logic rxd_sync;
    logic [DATA_W-1:0] modem_status_bits_q;
    logic [DATA_W-1:0] modem_status_bits_d;
    logic rts_n_q;
    logic rts_n_d;
    logic dtr_n_q;
    logic dtr_n_d;
    logic gp_out_q;
    logic gp_out_d;
    umc_tri_t irq_a_q;
    umc_tri_t irq_a_d;
    umc_tri_t irq_b_q;
    umc_tri_t irq_b_d;
    logic txd_q;
    logic txd_d;
    logic rx_core_q;
    logic rx_core_d;
    logic [4:0] mode_q;
    logic [4:0] mode_d;
    logic loop_on;
    logic wr_mc;
    logic wr_ef;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    assign sync_raw = {rxd_pin, modem_in_n};

    generate
        for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    sync_1_q[i] <= 1'b1;
                    sync_2_q[i] <= 1'b1;
                end else begin
                    sync_1_q[i] <= sync_raw[i];
                    sync_2_q[i] <= sync_1_q[i];
                end
            end
        end
    endgenerate

    assign lines_n = sync_2_q[LINES_W-1:0];
    assign rxd_sync = sync_2_q[LINES_W];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign wr_mc = reg_wr && (reg_addr == MODEM_CTRL_OFS);
    assign wr_ef = reg_wr && (reg_addr == ENH_FEAT_OFS);

    always_comb begin
        modem_line_control_d = modem_line_control_q;
        enhanced_feature_reg_d = enhanced_feature_reg_q;
        if (wr_ef) begin
            enhanced_feature_reg_d = reg_wdata;
        end
        if (wr_mc) begin
            modem_line_control_d[MC_OPEN_HI:0] = reg_wdata[MC_OPEN_HI:0];
            if (enhanced_feature_reg_q[EF_WR_EN]) begin
                modem_line_control_d[MC_PROT_HI:MC_PROT_LO] =
                    reg_wdata[MC_PROT_HI:MC_PROT_LO];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            modem_line_control_q <= MODEM_CTRL_RST;
            enhanced_feature_reg_q <= ENH_FEAT_RST;
        end else begin
            modem_line_control_q <= modem_line_control_d;
            enhanced_feature_reg_q <= enhanced_feature_reg_d;
        end
    end

    assign loop_on = modem_line_control_q[MC_LOOP];

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = ZERO_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                MODEM_CTRL_OFS: rdata_d = modem_line_control_q;
                ENH_FEAT_OFS: rdata_d = enhanced_feature_reg_q;
                MODEM_STAT_OFS: rdata_d = modem_status_bits_q;
                default: rdata_d = UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_q <= ZERO_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Modem status image
    // ------------------------------------------------------------
    always_comb begin
        modem_status_bits_d = ZERO_BYTE;
        if (loop_on) begin
            modem_status_bits_d[MS_CD] = modem_line_control_q[MC_IRQ_OP];
            modem_status_bits_d[MS_RI] = modem_line_control_q[MC_FIFO_RDY];
            modem_status_bits_d[MS_DSR] = modem_line_control_q[MC_DTR];
            modem_status_bits_d[MS_CTS] = modem_line_control_q[MC_RTS];
        end else begin
            modem_status_bits_d[MS_CD] = ~lines_n.cd;
            modem_status_bits_d[MS_RI] = ~lines_n.ri;
            modem_status_bits_d[MS_DSR] = ~lines_n.dsr;
            modem_status_bits_d[MS_CTS] = ~lines_n.cts;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            modem_status_bits_q <= ZERO_BYTE;
        end else begin
            modem_status_bits_q <= modem_status_bits_d;
        end
    end

    // ------------------------------------------------------------
    // Modem and interrupt pins
    // ------------------------------------------------------------
    always_comb begin
        if (enhanced_feature_reg_q[EF_AUTO_RTS]) begin
            rts_n_d = ~hw_rts_assert;
        end else begin
            rts_n_d = ~modem_line_control_q[MC_RTS];
        end
        dtr_n_d = ~modem_line_control_q[MC_DTR];
        gp_out_d = ~modem_line_control_q[MC_IRQ_OP];
        irq_a_d.o = irq_a_req;
        irq_b_d.o = irq_b_req;
        irq_a_d.oe = modem_line_control_q[MC_IRQ_OP];
        irq_b_d.oe = modem_line_control_q[MC_IRQ_OP];
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
            gp_out_q <= 1'b1;
            irq_a_q <= '0;
            irq_b_q <= '0;
        end else begin
            rts_n_q <= rts_n_d;
            dtr_n_q <= dtr_n_d;
            gp_out_q <= gp_out_d;
            irq_a_q <= irq_a_d;
            irq_b_q <= irq_b_d;
        end
    end

    assign rts_n = rts_n_q;
    assign dtr_n = dtr_n_q;
    assign general_output_pin = gp_out_q;
    assign channel_a_irq_out = irq_a_q;
    assign channel_b_irq_out = irq_b_q;

    // ------------------------------------------------------------
    // Serial loopback path
    // ------------------------------------------------------------
    always_comb begin
        if (loop_on) begin
            txd_d = 1'b1;
            rx_core_d = tx_from_core;
        end else begin
            txd_d = tx_from_core;
            rx_core_d = rxd_sync;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            txd_q <= 1'b1;
            rx_core_q <= 1'b1;
        end else begin
            txd_q <= txd_d;
            rx_core_q <= rx_core_d;
        end
    end

    assign txd_pin = txd_q;
    assign rx_to_core = rx_core_q;

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    always_comb begin
        mode_d[0] = modem_line_control_q[MC_THR_ACC];
        mode_d[1] = modem_line_control_q[MC_XON_ANY];
        mode_d[2] = modem_line_control_q[MC_FIFO_RDY];
        mode_d[3] = loop_on;
        mode_d[4] = enhanced_feature_reg_q[EF_AUTO_RTS];
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mode_q <= '0;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign flow_threshold_access = mode_q[0];
    assign xon_any_en = mode_q[1];
    assign fifo_rdy_en = mode_q[2];
    assign loopback_en = mode_q[3];
    assign auto_rts_en = mode_q[4];

    // ------------------------------------------------------------
    // Baud prescaler
    // ------------------------------------------------------------
    // Divide select
    umc_prescaler #(
        .DIV(PRE_DIV)
    ) u_prescaler (
        .mclk(mclk),
        .rst_b(rst_b),
        .div_sel(modem_line_control_q[MC_CLK_SEL]),
        .tick(baud_tick)
    );

endmodule : umc_modem_ctrl

// >>> src/umc_pkg.sv
// Constants and carrier types for the modem line control block
package umc_pkg;

    // ------------------------------------------------------------
    // Bus and register geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] ENH_FEAT_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] MODEM_CTRL_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] MODEM_STAT_OFS = 4'h6;

    localparam logic [DATA_W-1:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] ENH_FEAT_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Modem control field positions
    // ------------------------------------------------------------
    localparam int MC_CLK_SEL = 7;
    localparam int MC_THR_ACC = 6;
    localparam int MC_XON_ANY = 5;
    localparam int MC_LOOP = 4;
    localparam int MC_IRQ_OP = 3;
    localparam int MC_FIFO_RDY = 2;
    localparam int MC_RTS = 1;
    localparam int MC_DTR = 0;
    localparam int MC_PROT_HI = 7;
    localparam int MC_PROT_LO = 5;
    localparam int MC_OPEN_HI = 4;

    // ------------------------------------------------------------
    // Enhanced feature field positions
    // ------------------------------------------------------------
    localparam int EF_WR_EN = 4;
    localparam int EF_AUTO_RTS = 6;

    // ------------------------------------------------------------
    // Modem status field positions
    // ------------------------------------------------------------
    localparam int MS_CD = 7;
    localparam int MS_RI = 6;
    localparam int MS_DSR = 5;
    localparam int MS_CTS = 4;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    localparam int PRESCALE_DIV = 4;

    // Modem input lines, order cd, ri, dsr, cts
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } umc_lines_t;

    localparam int LINES_W = $bits(umc_lines_t);

    // Three-state pin drive
    typedef struct packed {
        logic o;
        logic oe;
    } umc_tri_t;

endpackage : umc_pkg

// >>> src/umc_prescaler.sv
// Clock prescaler producing the baud generator tick
module umc_prescaler
    import umc_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Control
    input wire logic div_sel,
    // Tick
    output logic tick
);

    localparam int CNT_W = $clog2(DIV);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = CNT_ZERO;
        tick_d = 1'b1;
        if (div_sel) begin
            tick_d = (cnt_q == CNT_LAST);
            cnt_d = tick_d ? CNT_ZERO : cnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_q <= CNT_ZERO;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : umc_prescaler

// >>> verification/umc_chk.sv
// Assertion checker for the modem line control block
module umc_chk
    import umc_pkg::*;
#(
    parameter int PRE_DIV = PRESCALE_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Pins and modes
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic general_output_pin,
    input wire logic irq_a_req,
    input wire umc_tri_t channel_a_irq_out,
    input wire logic tx_from_core,
    input wire logic txd_pin,
    input wire logic rx_to_core,
    input wire logic hw_rts_assert,
    input wire logic loopback_en,
    input wire logic auto_rts_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // ----
    // Properties
    // ----
    sequence ctl_wr_s;
        reg_wr && reg_addr == MODEM_CTRL_OFS;
    endsequence
    sequence loop_on_s;
        loopback_en && $past(loopback_en);
    endsequence
    op_irq_a: assert property (channel_a_irq_out.oe != general_output_pin)
        else $error("irq enable and general output disagree");
    irq_pass_a: assert property ($past(rst_b) |->
        channel_a_irq_out.o == $past(irq_a_req))
        else $error("irq output does not follow request");
    dtr_wr_a: assert property (ctl_wr_s |-> ##2 dtr_n == !$past(reg_wdata[MC_DTR], 2))
        else $error("dtr pin wrong after write");
    rts_wr_a: assert property (ctl_wr_s ##2 !auto_rts_en |->
        rts_n == !$past(reg_wdata[MC_RTS], 2))
        else $error("rts pin wrong after write");
    rts_auto_a: assert property (auto_rts_en |-> rts_n == !$past(hw_rts_assert))
        else $error("rts pin ignores flow hardware");
    loop_wr_a: assert property (ctl_wr_s |-> ##2
        loopback_en == $past(reg_wdata[MC_LOOP], 2))
        else $error("loopback mode not taken from write");
    loop_tx_a: assert property (loop_on_s |-> txd_pin)
        else $error("transmit pin active in loopback");
    loop_rx_a: assert property (loop_on_s |-> rx_to_core == $past(tx_from_core))
        else $error("receive path not looped");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == ZERO_BYTE)
        else $error("read data outside read cycle");
endmodule : umc_chk

bind umc_modem_ctrl umc_chk #(.PRE_DIV(PRE_DIV)) chk_u (.mclk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rts_n, .dtr_n, .general_output_pin, .irq_a_req,
    .channel_a_irq_out, .tx_from_core, .txd_pin, .rx_to_core, .hw_rts_assert,
    .loopback_en, .auto_rts_en);

// >>> verification/umc_modem_model.sv
// Behavioural modem on the far side of the handshake lines
module umc_modem_model
    import umc_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Line levels wanted, active high
    input wire umc_lines_t want,
    // Serial and handshake pins
    input wire logic txd_pin,
    output umc_lines_t modem_in_n,
    output logic rxd_pin
);
    assign modem_in_n = ~want;
    // Echo of the serial line
    always_ff @(posedge mclk) begin
        rxd_pin <= txd_pin;
    end
endmodule : umc_modem_model

// >>> verification/tb_uart_modem_control_register.sv
// Testbench for the modem line control block
module tb_uart_modem_control_register
    import umc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    logic mclk, rst_b, reg_wr, reg_rd, irq_a_req, irq_b_req, tx_from_core, hw_rts_assert;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_v;
    logic rts_n, dtr_n, general_output_pin, txd_pin, rxd_pin, rx_to_core, baud_tick;
    logic flow_threshold_access, xon_any_en, fifo_rdy_en, loopback_en, auto_rts_en;
    umc_lines_t modem_in_n, want;
    umc_tri_t channel_a_irq_out, channel_b_irq_out;
    int n_errors, n_tests, ticks;
    // ----
    // Instances
    // ----
    umc_modem_ctrl #(.PRE_DIV(DIV)) dut_u (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .modem_in_n, .rts_n, .dtr_n, .general_output_pin, .irq_a_req,
        .irq_b_req, .channel_a_irq_out, .channel_b_irq_out, .tx_from_core, .txd_pin,
        .rxd_pin, .rx_to_core, .hw_rts_assert, .flow_threshold_access, .xon_any_en,
        .fifo_rdy_en, .loopback_en, .auto_rts_en, .baud_tick);
    umc_modem_model model_u (.mclk, .want, .txd_pin, .modem_in_n, .rxd_pin);
    // ----
    // Tasks
    // ----
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic chk8(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask : chk1
    task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
        chk8(nm, e, rd_v);
    endtask : rdc
    task automatic tick_cnt(input int e);
        ticks = 0;
        repeat (16) begin
            @(posedge mclk);
            #1;
            ticks += int'(baud_tick);
        end
        chk8("ticks", 8'(e), 8'(ticks));
    endtask : tick_cnt
    task automatic close_out;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // ----
    // Clock and watchdog
    // ----
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        close_out;
    end
    // ----
    // Tests
    // ----
    initial begin
        n_errors = 0;
        n_tests = 0;
        {reg_wr, reg_rd, irq_a_req, irq_b_req, hw_rts_assert, rst_b} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        tx_from_core = 1'b1;
        want = '0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        wt(2);
        rdc("ctl rst", MODEM_CTRL_OFS, MODEM_CTRL_RST);
        rdc("efr rst", ENH_FEAT_OFS, ENH_FEAT_RST);
        rdc("unmapped", 4'hF, UNMAPPED_RD);
        chk1("rts_n", 1'b1, rts_n);
        chk1("gop", 1'b1, general_output_pin);
        @(posedge mclk);
        irq_a_req <= 1'b1;
        irq_b_req <= 1'b1;
        wr(MODEM_CTRL_OFS, 8'hFF);
        rdc("ctl prot", MODEM_CTRL_OFS, 8'h1F);
        chk1("dtr_n", 1'b0, dtr_n);
        chk1("rts_n", 1'b0, rts_n);
        chk1("gop", 1'b0, general_output_pin);
        chk1("irq b oe", 1'b1, channel_b_irq_out.oe);
        chk1("irq b o", 1'b1, channel_b_irq_out.o);
        chk1("fifo rdy", 1'b1, fifo_rdy_en);
        chk1("xon any", 1'b0, xon_any_en);
        for (int v = 16; v < 32; v++) begin
            wr(MODEM_CTRL_OFS, 8'(v));
            rdc("loop", MODEM_STAT_OFS, {v[3], v[2], v[0], v[1], 4'h0});
        end
        chk1("txd loop", 1'b1, txd_pin);
        @(posedge mclk) tx_from_core <= 1'b0;
        wt(3);
        chk1("rx loop", 1'b0, rx_to_core);
        wr(MODEM_CTRL_OFS, 8'h00);
        wt(1);
        chk1("gop", 1'b1, general_output_pin);
        chk1("irq b oe", 1'b0, channel_b_irq_out.oe);
        chk1("txd", 1'b0, txd_pin);
        chk1("fifo rdy", 1'b0, fifo_rdy_en);
        chk1("loop off", 1'b0, loopback_en);
        wt(6);
        chk1("rx pin", 1'b0, rx_to_core);
        @(posedge mclk) want <= 4'hA;
        wt(6);
        rdc("stat pins", MODEM_STAT_OFS, 8'hA0);
        wr(MODEM_STAT_OFS, 8'hFF);
        rdc("stat ro", MODEM_STAT_OFS, 8'hA0);
        wr(ENH_FEAT_OFS, 8'h10);
        wr(MODEM_CTRL_OFS, 8'hE0);
        rdc("ctl open", MODEM_CTRL_OFS, 8'hE0);
        chk1("thr acc", 1'b1, flow_threshold_access);
        chk1("xon any", 1'b1, xon_any_en);
        tick_cnt(16 / DIV);
        wr(MODEM_CTRL_OFS, 8'h20);
        rdc("ctl open", MODEM_CTRL_OFS, 8'h20);
        chk1("thr acc", 1'b0, flow_threshold_access);
        tick_cnt(16);
        wr(ENH_FEAT_OFS, 8'h50);
        wr(MODEM_CTRL_OFS, 8'h02);
        wt(2);
        chk1("auto rts", 1'b1, auto_rts_en);
        chk1("rts auto", 1'b1, rts_n);
        @(posedge mclk) hw_rts_assert <= 1'b1;
        wt(2);
        chk1("rts auto", 1'b0, rts_n);
        @(posedge mclk) rst_b <= 1'b0;
        wt(2);
        @(posedge mclk) rst_b <= 1'b1;
        wt(2);
        rdc("efr rst", ENH_FEAT_OFS, ENH_FEAT_RST);
        chk1("rts_n", 1'b1, rts_n);
        close_out;
    end
endmodule : tb_uart_modem_control_register
